//--- logic/drt_ctrl.sv
// Memory controller end: command spacing, self refresh, read capture
`timescale 1ns/1ps
`include "drt_defs.svh"
module drt_ctrl (
  input wire logic core_clk_i, // Core clock, 200 MHz
  input wire logic rst_b_i, // Synchronous reset, active low
  drt_if.ctrl bus, // Command pins and read bus
  input wire logic req_valid_i, // Request present
  input wire drt_pkg::drt_req_t req_kind_i, // Request kind
  input wire logic [1:0] req_bank_i, // Target bank
  input wire logic [11:0] req_addr_i, // Row or column
  input wire logic req_ap_i, // Auto precharge, or all banks
  output logic req_ready_o, // Request taken this cycle
  output logic req_error_o, // Taken request was dropped
  output logic [63:0] rd_data_o, // Captured element pair
  output logic rd_valid_o, // Pair valid pulse
  output logic self_refresh_o // Link in self refresh or in its exit wait
);
  // Whole controller state
  typedef struct packed {
    drt_pkg::drt_ctrl_st_t st;
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [1:0] bank;
    logic [11:0] addr;
    logic [7:0] xsr;
    logic [3:0] rrd;
    logic [3:0] rd_gap;
    logic [3:0] open;
    logic [3:0][3:0] rcd;
    logic [3:0][3:0] rc;
    logic err;
    logic [63:0] rd_data;
    logic rd_valid;
  } drt_ctrl_reg_t;

  drt_ctrl_reg_t q; // Registered state
  drt_ctrl_reg_t d; // Next state
  logic run; // Normal command state
  logic sr; // In self refresh
  logic ok; // Timing allows the request now
  logic bad; // Request can never be legal now
  logic go; // Issue the request

  // Legality, issue and timers
  always_comb begin
    d = q;
    run = (q.st == drt_pkg::CS_RUN);
    sr = (q.st == drt_pkg::CS_SR);
    ok = 1'b0;
    bad = 1'b0;
    // Idle pins carry a no operation every cycle
    d.cs_b = 1'b0;
    d.ras_b = 1'b1;
    d.cas_b = 1'b1;
    d.we_b = 1'b1;
    d.err = 1'b0;
    d.rd_valid = bus.dq_oe;
    if (bus.dq_oe) begin
      d.rd_data = bus.dq_line;
    end
    if (q.rrd != 4'h0) begin
      d.rrd = q.rrd - 4'h1;
    end
    if (q.rd_gap != 4'h0) begin
      d.rd_gap = q.rd_gap - 4'h1;
    end
    for (int b = 0; b < `DRT_BANKS; b++) begin
      if (q.rcd[b] != 4'h0) begin
        d.rcd[b] = q.rcd[b] - 4'h1;
      end
      if (q.rc[b] != 4'h0) begin
        d.rc[b] = q.rc[b] - 4'h1;
      end
    end
    unique case (req_kind_i)
      drt_pkg::REQ_ACT: begin
        bad = sr || q.open[req_bank_i];
        ok = run && q.rrd == 4'h0 && q.rc[req_bank_i] == 4'h0;
      end
      drt_pkg::REQ_READ: begin
        bad = sr || !q.open[req_bank_i];
        ok = run && q.rcd[req_bank_i] == 4'h0 && q.rd_gap == 4'h0;
      end
      drt_pkg::REQ_PRE: begin
        bad = sr;
        ok = run && q.rd_gap == 4'h0;
      end
      drt_pkg::REQ_SR_ENTER: begin
        bad = sr || (|q.open);
        ok = run;
      end
      drt_pkg::REQ_SR_EXIT: begin
        bad = !sr;
        ok = 1'b1;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    go = req_valid_i && ok && !bad;
    d.err = req_valid_i && bad;
    if (q.st == drt_pkg::CS_EXIT && q.xsr == 8'h0) begin
      d.st = drt_pkg::CS_RUN;
    end else if (q.st == drt_pkg::CS_EXIT) begin
      d.xsr = q.xsr - 8'h1;
    end
    if (go) begin
      d.bank = req_bank_i;
      d.addr = req_addr_i;
      unique case (req_kind_i)
        drt_pkg::REQ_ACT: begin
          d.ras_b = 1'b0;
          d.open[req_bank_i] = 1'b1;
          d.rcd[req_bank_i] = 4'(`DRT_RCD_CYC - 1);
          d.rc[req_bank_i] = 4'(`DRT_RC_CYC - 1);
          d.rrd = 4'(`DRT_RRD_CYC - 1);
        end
        drt_pkg::REQ_READ: begin
          d.cas_b = 1'b0;
          d.addr[`DRT_AP_BIT] = req_ap_i;
          d.rd_gap = 4'(`DRT_RD_TO_PRE_CYC - 1);
          if (req_ap_i) begin
            d.open[req_bank_i] = 1'b0;
          end
        end
        drt_pkg::REQ_PRE: begin
          d.ras_b = 1'b0;
          d.we_b = 1'b0;
          d.addr[`DRT_AP_BIT] = req_ap_i;
          if (req_ap_i) begin
            d.open = 4'h0;
          end else begin
            d.open[req_bank_i] = 1'b0;
          end
        end
        drt_pkg::REQ_SR_ENTER: begin
          d.ras_b = 1'b0;
          d.cas_b = 1'b0;
          d.cke = 1'b0;
          d.st = drt_pkg::CS_SR;
        end
        drt_pkg::REQ_SR_EXIT: begin
          d.cke = 1'b1;
          d.st = drt_pkg::CS_EXIT;
          d.xsr = 8'(`DRT_SR_EXIT_NOP_CYC - 1);
        end
        default: begin
          d.err = 1'b1;
        end
      endcase
    end
  end

  // State register; pins idle deselected with enable high
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.cke <= 1'b1;
      q.cs_b <= 1'b1;
      q.ras_b <= 1'b1;
      q.cas_b <= 1'b1;
      q.we_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Pin and user outputs; no write path, so no turnaround is needed
  assign bus.cke = q.cke;
  assign bus.cs_b = q.cs_b;
  assign bus.ras_b = q.ras_b;
  assign bus.cas_b = q.cas_b;
  assign bus.we_b = q.we_b;
  assign bus.bank = q.bank;
  assign bus.addr = q.addr;
  assign req_ready_o = ok || bad;
  assign req_error_o = q.err;
  assign rd_data_o = q.rd_data;
  assign rd_valid_o = q.rd_valid;
  assign self_refresh_o = (q.st != drt_pkg::CS_RUN);
endmodule

//--- common/drt_defs.svh
// Constants shared by both ends of the DRAM read and refresh link
`ifndef DRT_DEFS_SVH
`define DRT_DEFS_SVH
`define DRT_CLK_PERIOD_PS 5000
`define DRT_NS_TO_CYC(ns) ((((ns) * 1000) + `DRT_CLK_PERIOD_PS - 1) / `DRT_CLK_PERIOD_PS)
`define DRT_DQ_W 32
`define DRT_ADDR_W 12
`define DRT_BANKS 4
`define DRT_COL_W 4
`define DRT_AP_BIT 8
`define DRT_READ_LATENCY 5
`define DRT_BURST_LEN 4
`define DRT_TERM_OFF_CYC (`DRT_BURST_LEN / 2 + 2)
`define DRT_T_RCD_NS 16
`define DRT_T_RC_NS 45
`define DRT_T_RRD_NS 10
`define DRT_T_RAS_NS 35
`define DRT_RCD_CYC `DRT_NS_TO_CYC(`DRT_T_RCD_NS)
`define DRT_RC_CYC `DRT_NS_TO_CYC(`DRT_T_RC_NS)
`define DRT_RRD_CYC `DRT_NS_TO_CYC(`DRT_T_RRD_NS)
`define DRT_RAS_CYC `DRT_NS_TO_CYC(`DRT_T_RAS_NS)
`define DRT_SR_EXIT_NOP_CYC 200
`define DRT_RD_TO_PRE_CYC 2
`define DRT_STRB_DATA 2'h2
`define DRT_STRB_POST 2'h3
`endif

//--- common/drt_pkg.sv
// Types and command decoding for the DRAM read and refresh link
package drt_pkg;
  // Decoded command on the pins
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS
  } drt_cmd_t;
  // Device power state
  typedef enum logic {DS_RUN, DS_SR} drt_dev_st_t;
  // Controller power state
  typedef enum logic [1:0] {CS_RUN, CS_SR, CS_EXIT} drt_ctrl_st_t;
  // Controller user request kinds
  typedef enum logic [2:0] {
    REQ_ACT, REQ_READ, REQ_PRE, REQ_SR_ENTER, REQ_SR_EXIT
  } drt_req_t;
  // One snooped read travelling down the latency pipe
  typedef struct packed {
    logic v;
    logic ap;
    logic [1:0] bank;
    logic [3:0] col;
  } drt_slot_t;

  // Pin encoding to command; deselect reads as no operation
  function automatic drt_cmd_t drt_decode(input logic cs_b,
      input logic ras_b, input logic cas_b, input logic we_b);
    drt_cmd_t c;
    c = CMD_NOP;
    if (!cs_b) begin
      unique case ({ras_b, cas_b, we_b})
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction
endpackage

//--- common/drt_if.sv
// Pin bundle between memory controller and DRAM device
`timescale 1ns/1ps
interface drt_if;
  logic cke;
  logic cs_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [63:0] dq;
  logic dq_oe;
  logic [1:0] read_strobe;
  logic read_strobe_oe;
  logic [63:0] dq_line;
  logic [1:0] read_strobe_line;
  // Undriven lines float high on the termination
  assign dq_line = dq_oe ? dq : '1;
  assign read_strobe_line = read_strobe_oe ? read_strobe : 2'h3;
  modport dev (input cke, cs_b, ras_b, cas_b, we_b, bank, addr,
    output dq, dq_oe, read_strobe, read_strobe_oe);
  modport ctrl (output cke, cs_b, ras_b, cas_b, we_b, bank, addr,
    input dq_line, dq_oe, read_strobe_line, read_strobe_oe);
endinterface

//--- logic/drt_dev.sv
// DRAM device end: read snooping, terminators, self refresh, reads
// Functional notes
// - Snoop READ encoding, ignoring chip select.
// - Data terminators off from latency-1, four clocks.
// - Command and address terminators always on.
// - Refresh with clock enable low enters self refresh.
// - Loop off in self refresh, reset on exit.
// - Termination disabled throughout self refresh.
// - Controller waits 200 clocks before READ.
// - Controller exits with stable clock, then NOPs.
// - Controller issues 200 NOP clocks after exit.
// - Controller activates a row before access.
// - Controller spaces access after activate.
// - Same bank activates need precharge, cycle time.
// - Different bank activates spaced by delay.
// - Auto precharge at burst end, after minimum.
// - First element one latency after READ.
// - Burst of four in sequential order.
// - Preamble high then low before data.
// - Postamble after last element; strobe toggles on data.
// - Release lines after burst; never truncate.
// - Controller writes two clocks after read data; this controller has no write path.
// - Precharge may follow READ after two clocks.
// - Every READ also disables data terminators.
// - Auto precharge bit chosen per command.
`timescale 1ns/1ps
`include "drt_defs.svh"
module drt_dev (
  input wire logic core_clk_i, // Core clock, 200 MHz
  input wire logic rst_b_i, // Synchronous reset, active low
  drt_if.dev bus, // Command pins and read bus
  input wire logic ld_en_i, // Array load strobe
  input wire logic [5:0] ld_addr_i, // Array word {bank,column}
  input wire logic [31:0] ld_data_i, // Array load data
  output logic data_term_en_o, // Data terminators enabled
  output logic cmd_term_en_o, // Command terminators enabled
  output logic dll_en_o, // Delay-locked loop enabled
  output logic dll_reset_o, // Loop reset pulse
  output logic self_refresh_o, // In self refresh
  output logic ap_pre_o, // Auto precharge pulse
  output logic [1:0] ap_pre_bank_o, // Bank of that precharge
  output logic [3:0] bank_open_o // Row open per bank
);
  localparam int RL = `DRT_READ_LATENCY;
  localparam int PN = RL + 2;
  localparam logic [3:0] RAS_CYC = 4'(`DRT_RAS_CYC);

  // Whole device state
  typedef struct packed {
    drt_pkg::drt_dev_st_t st;
    logic cke_q;
    drt_pkg::drt_slot_t [PN:1] pipe;
    logic [63:0] dq;
    logic dq_oe;
    logic [1:0] strb;
    logic strb_oe;
    logic term_en;
    logic dll_en;
    logic dll_rst;
    logic [3:0] open;
    logic [3:0] ap_pend;
    logic [3:0][3:0] ras_cnt;
    logic pre_pls;
    logic [1:0] pre_bank;
  } drt_dev_reg_t;

  drt_dev_reg_t q; // Registered state
  drt_dev_reg_t d; // Next state
  logic [31:0] mem [64]; // Storage, 4 banks of 16 columns
  drt_pkg::drt_cmd_t cmd; // Decoded command
  drt_pkg::drt_slot_t slot; // Read seen this cycle
  logic run; // Commands are honoured
  logic win; // Terminator off window open
  logic pre_done; // One precharge per cycle

  // Word index of burst element i; order wraps inside four columns
  function automatic logic [5:0] elem_idx(input drt_pkg::drt_slot_t s,
      input logic [1:0] i);
    return {s.bank, s.col[3:2], s.col[1:0] + i};
  endfunction

  // Array load port from the core side
  always_ff @(posedge core_clk_i) begin
    if (ld_en_i) begin
      mem[ld_addr_i] <= ld_data_i;
    end
  end

  // Next-state logic
  always_comb begin
    d = q;
    cmd = drt_pkg::drt_decode(bus.cs_b, bus.ras_b, bus.cas_b, bus.we_b);
    run = (q.st == drt_pkg::DS_RUN) && bus.cke;
    slot = '0;
    win = 1'b0;
    pre_done = 1'b0;
    d.cke_q = bus.cke;
    d.dll_rst = 1'b0;
    d.pre_pls = 1'b0;
    if (run && bus.ras_b && !bus.cas_b && bus.we_b) begin
      slot.v = 1'b1;
      slot.ap = bus.addr[`DRT_AP_BIT];
      slot.bank = bus.bank;
      slot.col = bus.addr[3:0];
    end
    d.pipe = {q.pipe[PN-1:1], slot};
    // Power state; in self refresh only clock enable is looked at
    unique case (q.st)
      drt_pkg::DS_RUN: begin
        if (!bus.cke && q.cke_q && cmd == drt_pkg::CMD_REF) begin
          d.st = drt_pkg::DS_SR;
          d.dll_en = 1'b0;
        end
      end
      drt_pkg::DS_SR: begin
        if (bus.cke) begin
          d.st = drt_pkg::DS_RUN;
          d.dll_en = 1'b1;
          d.dll_rst = 1'b1;
        end
      end
    endcase
    // Per-bank row state and auto precharge
    for (int b = 0; b < `DRT_BANKS; b++) begin
      if (q.ras_cnt[b] != RAS_CYC) begin
        d.ras_cnt[b] = q.ras_cnt[b] + 4'h1;
      end
      if (run && cmd == drt_pkg::CMD_ACT && bus.bank == 2'(b)) begin
        d.open[b] = 1'b1;
        d.ras_cnt[b] = 4'h0;
        d.ap_pend[b] = 1'b0;
      end
      if (run && cmd == drt_pkg::CMD_PRE &&
          (bus.addr[`DRT_AP_BIT] || bus.bank == 2'(b))) begin
        d.open[b] = 1'b0;
      end
      if (q.pipe[RL+1].v && q.pipe[RL+1].ap &&
          q.pipe[RL+1].bank == 2'(b)) begin
        d.ap_pend[b] = 1'b1;
      end
      if (q.ap_pend[b] && q.ras_cnt[b] == RAS_CYC && !pre_done) begin
        d.open[b] = 1'b0;
        d.ap_pend[b] = 1'b0;
        d.pre_pls = 1'b1;
        d.pre_bank = 2'(b);
        pre_done = 1'b1;
      end
    end
    // Read data, older burst first so it is never cut short; a read one clock behind it loses its first pair
    d.dq = '0;
    if (q.pipe[RL].v) begin
      d.dq = {mem[elem_idx(q.pipe[RL], 2'h2)],
              mem[elem_idx(q.pipe[RL], 2'h3)]};
    end else if (q.pipe[RL-1].v) begin
      d.dq = {mem[elem_idx(q.pipe[RL-1], 2'h0)],
              mem[elem_idx(q.pipe[RL-1], 2'h1)]};
    end
    d.dq_oe = q.pipe[RL].v || q.pipe[RL-1].v;
    // Strobe: data beats beat over preamble, preamble over postamble
    d.strb = 2'h0;
    d.strb_oe = 1'b1;
    if (d.dq_oe) begin
      d.strb = `DRT_STRB_DATA;
    end else if (q.pipe[RL-2].v) begin
      d.strb = `DRT_STRB_DATA;
    end else if (q.pipe[RL+1].v) begin
      d.strb = `DRT_STRB_POST;
    end else begin
      d.strb_oe = 1'b0;
    end
    for (int k = RL - 1; k <= PN; k++) begin
      win = win | d.pipe[k].v;
    end
    d.term_en = !win && (d.st == drt_pkg::DS_RUN);
  end

  // State register; loop and terminators come up enabled
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.dll_en <= 1'b1;
      q.term_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Pin and status outputs
  assign bus.dq = q.dq;
  assign bus.dq_oe = q.dq_oe;
  assign bus.read_strobe = q.strb;
  assign bus.read_strobe_oe = q.strb_oe;
  assign data_term_en_o = q.term_en;
  assign cmd_term_en_o = 1'b1;
  assign dll_en_o = q.dll_en;
  assign dll_reset_o = q.dll_rst;
  assign self_refresh_o = (q.st == drt_pkg::DS_SR);
  assign ap_pre_o = q.pre_pls;
  assign ap_pre_bank_o = q.pre_bank;
  assign bank_open_o = q.open;
endmodule

//--- test/drt_checker.sv
// Pin-level assertions on the controller to device link
`timescale 1ns/1ps
module drt_checker (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic cke, // Clock enable
  input wire logic cs_b, // Chip select
  input wire logic ras_b, // Row strobe
  input wire logic cas_b, // Column strobe
  input wire logic we_b, // Write enable
  input wire logic [1:0] bank, // Bank address
  input wire logic dq_oe, // Device drives data
  input wire logic [1:0] read_strobe, // Strobe halves
  input wire logic read_strobe_oe // Device drives strobe
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Read snoop ignores chip select, as the device does
  logic rd_c, act_c, pre_c, cmd_c, cke_q;
  // Clocks since each event, saturating so old events stay legal
  logic [3:0] rd_age_q, act_age_q;
  logic [3:0] bk_age_q [4];
  logic [7:0] xsr_age_q;
  assign rd_c = cke && ras_b && !cas_b && we_b;
  assign act_c = cke && !cs_b && !ras_b && cas_b && we_b;
  assign pre_c = !cs_b && !ras_b && cas_b && !we_b;
  assign cmd_c = !cs_b && !(ras_b && cas_b && we_b);
  // Age counters restart at one on their event
  always_ff @(posedge core_clk_i) begin
    cke_q <= cke;
    if (!rst_b_i) begin
      rd_age_q <= 4'hf;
      act_age_q <= 4'hf;
      xsr_age_q <= 8'hff;
      for (int i = 0; i < 4; i++) bk_age_q[i] <= 4'hf;
    end else begin
      rd_age_q <= rd_c ? 4'h1 : rd_age_q + 4'(rd_age_q != 4'hf);
      act_age_q <= act_c ? 4'h1 : act_age_q + 4'(act_age_q != 4'hf);
      xsr_age_q <= (cke && !cke_q) ? 8'h1 :
        xsr_age_q + 8'(xsr_age_q != 8'hff);
      for (int i = 0; i < 4; i++) bk_age_q[i] <= (act_c && bank == i) ?
        4'h1 : bk_age_q[i] + 4'(bk_age_q[i] != 4'hf);
    end
  end
  // A read three clocks behind another is not checked; its preamble wins over the earlier postamble
  preamble_lead_a:
  assert property (rd_c && rd_age_q != 4'h3 |-> ##4 (read_strobe_oe &&
    read_strobe == 2'h2)) else $error("missing read preamble");
  data_at_latency_a:
  assert property (rd_c |-> ##5 dq_oe [*2]) else $error("late read data");
  strobe_with_data_a:
  assert property (dq_oe |-> read_strobe_oe && read_strobe == 2'h2)
    else $error("strobe wrong during data");
  postamble_end_a:
  assert property ($fell(dq_oe) |-> read_strobe_oe && read_strobe == 2'h3)
    else $error("missing postamble");
  release_after_post_a:
  assert property (read_strobe_oe && read_strobe == 2'h3 |=>
    !read_strobe_oe || read_strobe == 2'h2) else $error("strobe not freed");
  bank_act_gap_a:
  assert property (act_c |-> act_age_q >= 4'h2) else $error("act too close");
  same_bank_act_a:
  assert property (act_c |-> bk_age_q[bank] >= 4'h9)
    else $error("same bank act too close");
  read_after_act_a:
  assert property (rd_c && !cs_b |-> bk_age_q[bank] >= 4'h4)
    else $error("read too soon after act");
  pre_after_read_a:
  assert property (pre_c |-> rd_age_q >= 4'h2) else $error("early pre");
  exit_quiet_a:
  assert property (cmd_c |-> xsr_age_q >= 8'hc8)
    else $error("command during exit wait");
  sr_entry_ref_a:
  assert property ($fell(cke) |-> !cs_b && !ras_b && !cas_b && we_b)
    else $error("clock enable dropped without refresh");
  no_write_a:
  assert property (!(!cs_b && ras_b && !cas_b && !we_b))
    else $error("write issued");
endmodule

//--- test/tb_top.sv
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, ld_en, req_valid, req_ap, e;
  logic [5:0] ld_addr;
  logic [31:0] ld_data;
  drt_pkg::drt_req_t req_kind;
  logic [1:0] req_bank, ap_bank;
  logic [11:0] req_addr;
  logic term_en, cmd_term, dll_en, dll_rst, dev_sr, ap_pre, ready, err;
  logic rvalid, ctrl_sr;
  logic [3:0] bank_open;
  logic [63:0] rdata;
  int fails, checked, cyc, rd_t, rd_gap, low_run, last_run, fall_d;
  int dll_pulses, ap_cnt, wait_n;
  logic [63:0] got [$];
  logic [63:0] exp [$];
  drt_if lnk ();
  drt_dev drt_dev_inst (.core_clk_i(clk), .rst_b_i(rst_b), .bus(lnk),
    .ld_en_i(ld_en), .ld_addr_i(ld_addr), .ld_data_i(ld_data),
    .data_term_en_o(term_en), .cmd_term_en_o(cmd_term),
    .dll_en_o(dll_en), .dll_reset_o(dll_rst), .self_refresh_o(dev_sr),
    .ap_pre_o(ap_pre), .ap_pre_bank_o(ap_bank), .bank_open_o(bank_open));
  drt_ctrl drt_ctrl_inst (.core_clk_i(clk), .rst_b_i(rst_b), .bus(lnk),
    .req_valid_i(req_valid), .req_kind_i(req_kind), .req_bank_i(req_bank),
    .req_addr_i(req_addr), .req_ap_i(req_ap), .req_ready_o(ready),
    .req_error_o(err), .rd_data_o(rdata), .rd_valid_o(rvalid),
    .self_refresh_o(ctrl_sr));
  drt_checker drt_checker_inst (.core_clk_i(clk), .rst_b_i(rst_b),
    .cke(lnk.cke), .cs_b(lnk.cs_b), .ras_b(lnk.ras_b), .cas_b(lnk.cas_b),
    .we_b(lnk.we_b), .bank(lnk.bank), .dq_oe(lnk.dq_oe),
    .read_strobe(lnk.read_strobe), .read_strobe_oe(lnk.read_strobe_oe));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Edge monitor: reads on pins, terminator window, pulses, data
  always @(posedge clk) begin
    if (lnk.cke && lnk.ras_b && !lnk.cas_b && lnk.we_b) begin
      rd_gap = cyc - rd_t;
      rd_t = cyc;
    end
    if (!term_en && !dev_sr) begin
      if (low_run == 0) fall_d = cyc - rd_t;
      low_run++;
    end else if (low_run != 0) begin
      last_run = low_run;
      low_run = 0;
    end
    if (dll_rst) dll_pulses++;
    if (ap_pre) ap_cnt++;
    if (rvalid) got.push_back(rdata);
    cyc++;
  end
  function automatic logic [31:0] pat(input logic [1:0] b,
      input logic [3:0] c);
    return {24'hc0de5a, 2'h0, b, c};
  endfunction
  task automatic chk(input logic [63:0] act, input logic [63:0] want,
      input string what);
    checked++;
    if (act !== want) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request, held until taken; error sampled the cycle after.
  // Ready is read at the rising edge, where the controller takes it;
  // reading it right after the falling-edge drive would see a stale value.
  task automatic req(input drt_pkg::drt_req_t k, input logic [1:0] b,
      input logic [11:0] a, input logic ap);
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_bank = b;
    req_addr = a;
    req_ap = ap;
    wait_n = 0;
    @(posedge clk);
    while (ready !== 1'b1 && wait_n < 400) begin
      @(posedge clk);
      wait_n++;
    end
    if (wait_n >= 400) begin
      fails++;
      $display("unexpected at %0t: request never taken", $time);
      finish_test();
    end else begin
      @(negedge clk);
      e = err;
      req_valid = 1'b0;
    end
  endtask
  // Read with wrapped sequential order inside an aligned group of four
  task automatic rd(input logic [1:0] b, input logic [3:0] c,
      input logic ap);
    logic [1:0] lo;
    req(drt_pkg::REQ_READ, b, {3'h0, ap, 4'h0, c}, ap);
    chk(e, 1'b0, "read dropped");
    for (int k = 0; k < 4; k += 2) begin
      lo = c[1:0] + 2'(k);
      exp.push_back({pat(b, {c[3:2], lo}), pat(b, {c[3:2], lo + 2'h1})});
    end
  endtask
  // Wait for all pairs, then compare in order
  task automatic drain();
    int n;
    n = 0;
    while (got.size() < exp.size() && n < 50) begin
      @(negedge clk);
      n++;
    end
    // A burst that never shows up ends the run here
    if (n >= 50) begin
      fails++;
      $display("unexpected at %0t: read data never arrived", $time);
      finish_test();
    end
    repeat (4) @(negedge clk);
    chk(got.size(), exp.size(), "pair count");
    foreach (exp[i]) chk(got[i], exp[i], "read pair");
    got.delete();
    exp.delete();
  endtask
  initial begin
    {rst_b, ld_en, req_valid, req_ap, ld_addr, ld_data} = '0;
    {req_bank, req_addr} = '0;
    req_kind = drt_pkg::REQ_ACT;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    chk({term_en, cmd_term, dll_en, dll_rst, dev_sr, bank_open}, 9'h1c0,
      "reset state");
    // Fill the array with an address-tagged pattern
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      ld_en = 1'b1;
      ld_addr = i[5:0];
      ld_data = pat(i[5:4], i[3:0]);
    end
    @(negedge clk);
    ld_en = 1'b0;
    // Single read from a mid-group column
    req(drt_pkg::REQ_ACT, 2'h1, 12'h0a5, 1'b0);
    // The device opens the row one edge after the pins show it
    @(negedge clk);
    chk(bank_open, 4'h2, "row open");
    rd(2'h1, 4'h5, 1'b0);
    drain();
    chk(fall_d, 4, "terminator off start");
    chk(last_run, 4, "terminator off length");
    // Back-to-back reads, the second closing the row
    rd(2'h1, 4'h0, 1'b0);
    rd(2'h1, 4'hb, 1'b1);
    drain();
    chk(rd_gap, 2, "read spacing");
    chk(last_run, 6, "merged terminator window");
    chk({ap_cnt, ap_bank, bank_open}, {32'd1, 2'h1, 4'h0}, "autopre");
    // Refused requests and all-bank precharge
    req(drt_pkg::REQ_READ, 2'h2, 12'h000, 1'b0);
    chk(e, 1'b1, "read to closed bank");
    req(drt_pkg::REQ_ACT, 2'h2, 12'h011, 1'b0);
    req(drt_pkg::REQ_ACT, 2'h3, 12'h022, 1'b0);
    req(drt_pkg::REQ_ACT, 2'h2, 12'h033, 1'b0);
    chk(e, 1'b1, "act to open bank");
    req(drt_pkg::REQ_SR_ENTER, 2'h0, 12'h000, 1'b0);
    chk(e, 1'b1, "refresh with open bank");
    req(drt_pkg::REQ_SR_EXIT, 2'h0, 12'h000, 1'b0);
    chk(e, 1'b1, "exit while running");
    req(drt_pkg::REQ_PRE, 2'h0, 12'h100, 1'b1);
    repeat (2) @(negedge clk);
    chk(bank_open, 4'h0, "all banks closed");
    // Self refresh entry, refused read, exit
    req(drt_pkg::REQ_SR_ENTER, 2'h0, 12'h000, 1'b0);
    repeat (3) @(negedge clk);
    chk({dev_sr, dll_en, term_en, ctrl_sr, lnk.cke}, 5'h12, "in sr");
    req(drt_pkg::REQ_READ, 2'h1, 12'h000, 1'b0);
    chk(e, 1'b1, "read in self refresh");
    req(drt_pkg::REQ_SR_EXIT, 2'h0, 12'h000, 1'b0);
    repeat (3) @(negedge clk);
    chk({dev_sr, dll_en, term_en, ctrl_sr, lnk.cke}, 5'h0f, "exit");
    chk(dll_pulses, 1, "loop reset pulse");
    req(drt_pkg::REQ_ACT, 2'h1, 12'h0a5, 1'b0);
    chk(wait_n > 190, 1'b1, "exit wait");
    rd(2'h1, 4'h3, 1'b0);
    drain();
    finish_test();
  end
endmodule
